// File: design/baud_if.sv
`default_nettype none
interface baud_if;
  logic [11:0] divisor;
  logic reload;
  logic tick;

  modport ctrl (output divisor, output reload, input tick);
  modport gen (input divisor, input reload, output tick);
endinterface
`default_nettype wire

// File: design/baud_prescaler.sv
`default_nettype none
module baud_prescaler
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  baud_if.gen bif
);

  logic [11:0] count_reg;
  logic [11:0] count_next;
  logic tick_next;
  wire at_zero = (count_reg == 12'h000);

  // ----------------------------------------
  // Down counter, reloaded at zero and on baud low byte write
  // ----------------------------------------
  assign count_next = (bif.reload || at_zero) ? bif.divisor : count_reg - 12'h001;
  assign tick_next = at_zero && !bif.reload;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 12'h000;
      bif.tick <= 1'b0;
    end
    else if (clk_en)
    begin
      count_reg <= count_next;
      bif.tick <= tick_next;
    end
  end

endmodule
`default_nettype wire

// File: design/serial_port_ctrl.sv
// The APB register port is this design's own decision.
`default_nettype none
`include "serial_port_defs.svh"
module serial_port_ctrl
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_en,
  input wire logic rx_done_flag,
  input wire logic tx_done_flag,
  input wire logic buf_empty_flag,
  input wire logic rx_ninth_bit,
  input wire logic tx_shift_empty,
  input wire logic tx_buf_empty,
  output logic rx_done_irq,
  output logic tx_done_irq,
  output logic buf_empty_irq,
  output logic receiver_on,
  output logic rx_flush,
  output logic rx_err_flags_valid,
  output logic transmitter_on,
  output logic [1:0] op_mode,
  output logic [3:0] data_bits,
  output logic char_size_reserved,
  output logic parity_en,
  output logic parity_odd,
  output logic two_stop_bits,
  output logic lsb_first,
  output logic sample_on_rising,
  output logic change_on_rising,
  output logic clk_idle_high,
  output logic tx_ninth_bit,
  output logic [11:0] baud_divisor,
  output logic baud_tick
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [3:0] size_to_bits(input logic [2:0] code);
    logic [3:0] bits;
    bits = 4'h8;
    unique case (code)
      3'h0: bits = 4'h5;
      3'h1: bits = 4'h6;
      3'h2: bits = 4'h7;
      3'h3: bits = 4'h8;
      3'h7: bits = 4'h9;
      default: bits = 4'h8;
    endcase
    return bits;
  endfunction

  function automatic logic is_spi(input logic [7:0] fmt);
    return fmt[`FF_OP_MODE_HI:`FF_OP_MODE_LO] == MODE_MASTER_SPI;
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] enable_control_reg;
  logic [7:0] frame_format_reg;
  logic [7:0] baud_low_reg;
  logic [3:0] baud_high_reg;
  logic tx_active_reg;
  logic tx_active_next;

  baud_if bif ();

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [7:0] reg_index = paddr[9:2];
  wire addr_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire hit_enable = addr_aligned && (reg_index == `IDX_ENABLE_CONTROL);
  wire hit_format = addr_aligned && (reg_index == `IDX_FRAME_FORMAT);
  wire hit_baud_low = addr_aligned && (reg_index == `IDX_BAUD_LOW);
  wire hit_baud_high = addr_aligned && (reg_index == `IDX_BAUD_HIGH);
  wire hit_status = addr_aligned && (reg_index == `IDX_LINK_STATUS);
  wire addr_mapped = hit_enable || hit_format || hit_baud_low || hit_baud_high || hit_status;

  // Access completes at the edge where pready is already high
  wire access_end = psel && penable && pready;
  wire access_phase = psel && penable && !pready;
  wire wr_ok = access_end && pwrite && addr_mapped;
  wire wr_enable = wr_ok && hit_enable;
  wire wr_format = wr_ok && hit_format;
  wire wr_baud_low = wr_ok && hit_baud_low;
  wire wr_baud_high = wr_ok && hit_baud_high;

  // ----------------------------------------
  // Enable control write value
  // ----------------------------------------
  // Received ninth bit is read only and comes from the receive engine
  wire [7:0] enable_wr_value = {pwdata[7:2], 1'b0, pwdata[0]};
  wire [7:0] enable_next = wr_enable ? enable_wr_value : enable_control_reg;
  wire rx_en_now = enable_control_reg[`EC_RECEIVER_EN];
  wire tx_en_next = enable_next[`EC_TRANSMITTER_EN];
  wire rx_disable_event = wr_enable && rx_en_now && !enable_wr_value[`EC_RECEIVER_EN];

  // ----------------------------------------
  // Transmitter deferred disable
  // ----------------------------------------
  wire tx_drained = tx_shift_empty && tx_buf_empty;
  assign tx_active_next = tx_en_next || (tx_active_reg && !tx_drained);

  // ----------------------------------------
  // Format decode, by operating mode
  // ----------------------------------------
  wire spi_mode = is_spi(frame_format_reg);
  wire [1:0] mode_field = frame_format_reg[`FF_OP_MODE_HI:`FF_OP_MODE_LO];
  wire sync_mode = (mode_field == MODE_SYNC);
  wire [1:0] parity_field = frame_format_reg[`FF_PARITY_HI:`FF_PARITY_LO];
  wire bit_a = frame_format_reg[`FF_SIZE1_ORDER];
  wire bit_b = frame_format_reg[`FF_SIZE0_PHASE];
  wire polarity = frame_format_reg[`FF_POLARITY];
  wire [2:0] size_code = {enable_control_reg[`EC_CHAR_SIZE_MSB], bit_a, bit_b};

  // SPI frames are always eight bits
  wire [3:0] data_bits_d = spi_mode ? 4'h8 : size_to_bits(size_code);
  wire size_reserved_d = !spi_mode && (size_code inside {3'h4, 3'h5, 3'h6});
  wire parity_en_d = !spi_mode && parity_field[1];
  wire parity_odd_d = !spi_mode && (parity_field == PARITY_ODD);
  wire two_stop_d = !spi_mode && frame_format_reg[`FF_STOP_BITS];
  wire lsb_first_d = spi_mode && bit_a;
  wire phase = spi_mode && bit_b;

  // Leading edge is rising when polarity is low
  wire sample_rising_d = spi_mode ? !(polarity ^ phase) : (sync_mode && polarity);
  wire change_rising_d = spi_mode ? (polarity ^ phase) : (sync_mode && !polarity);
  wire idle_high_d = (spi_mode || sync_mode) && polarity;
  wire tx_ninth_d = !spi_mode && enable_control_reg[`EC_TX_NINTH_BIT];

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  wire rx_irq_d = enable_control_reg[`EC_RX_DONE_IRQ_EN] && global_irq_en && rx_done_flag;
  wire tx_irq_d = enable_control_reg[`EC_TX_DONE_IRQ_EN] && global_irq_en && tx_done_flag;
  wire be_irq_d = enable_control_reg[`EC_BUF_EMPTY_IRQ_EN] && global_irq_en && buf_empty_flag;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire rx_ninth_view = !spi_mode && rx_ninth_bit;
  wire [7:0] enable_read = {enable_control_reg[7:2], rx_ninth_view, enable_control_reg[0]};
  wire [7:0] status_read = {3'h0, tx_active_reg, rx_en_now, buf_empty_flag, tx_done_flag, rx_done_flag};
  wire [7:0] read_byte =
    hit_enable ? enable_read :
    hit_format ? frame_format_reg :
    hit_baud_low ? baud_low_reg :
    hit_baud_high ? {4'h0, baud_high_reg} :
    hit_status ? status_read : 8'h00;
  wire [31:0] rdata_d = (!pwrite && addr_mapped) ? {24'h000000, read_byte} : 32'h00000000;

  // ----------------------------------------
  // Baud prescaler link
  // ----------------------------------------
  assign bif.divisor = {baud_high_reg, baud_low_reg};
  assign bif.reload = wr_baud_low && clk_en;

  baud_prescaler prescaler_inst (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .bif(bif)
  );

  assign baud_tick = bif.tick;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= access_phase;
      prdata <= access_phase ? rdata_d : 32'h00000000;
      pslverr <= access_phase && !addr_mapped;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_control_reg <= `RST_ENABLE_CONTROL;
      frame_format_reg <= `RST_FRAME_FORMAT;
      baud_low_reg <= `RST_BAUD_LOW;
      baud_high_reg <= `RST_BAUD_HIGH;
    end
    else if (clk_en)
    begin
      enable_control_reg <= enable_next;
      if (wr_format)
      begin
        frame_format_reg <= pwdata[7:0];
      end
      if (wr_baud_low)
      begin
        baud_low_reg <= pwdata[7:0];
      end
      if (wr_baud_high)
      begin
        baud_high_reg <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // Enable and pin ownership state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_active_reg <= 1'b0;
      receiver_on <= 1'b0;
      rx_flush <= 1'b0;
      rx_err_flags_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_active_reg <= tx_active_next;
      receiver_on <= enable_next[`EC_RECEIVER_EN];
      rx_flush <= rx_disable_event;
      rx_err_flags_valid <= enable_next[`EC_RECEIVER_EN];
    end
  end

  assign transmitter_on = tx_active_reg;

  // ----------------------------------------
  // Decoded configuration and requests
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_done_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      buf_empty_irq <= 1'b0;
      op_mode <= 2'h0;
      data_bits <= 4'h8;
      char_size_reserved <= 1'b0;
      parity_en <= 1'b0;
      parity_odd <= 1'b0;
      two_stop_bits <= 1'b0;
      lsb_first <= 1'b0;
      sample_on_rising <= 1'b0;
      change_on_rising <= 1'b0;
      clk_idle_high <= 1'b0;
      tx_ninth_bit <= 1'b0;
      baud_divisor <= 12'h000;
    end
    else if (clk_en)
    begin
      rx_done_irq <= rx_irq_d;
      tx_done_irq <= tx_irq_d;
      buf_empty_irq <= be_irq_d;
      op_mode <= mode_field;
      data_bits <= data_bits_d;
      char_size_reserved <= size_reserved_d;
      parity_en <= parity_en_d;
      parity_odd <= parity_odd_d;
      two_stop_bits <= two_stop_d;
      lsb_first <= lsb_first_d;
      sample_on_rising <= sample_rising_d;
      change_on_rising <= change_rising_d;
      clk_idle_high <= idle_high_d;
      tx_ninth_bit <= tx_ninth_d;
      baud_divisor <= {baud_high_reg, baud_low_reg};
    end
  end

endmodule
`default_nettype wire

// File: design/serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_ENABLE_CONTROL 8'hc1
`define IDX_FRAME_FORMAT 8'hc2
`define IDX_BAUD_LOW 8'hc4
`define IDX_BAUD_HIGH 8'hc5
`define IDX_LINK_STATUS 8'hc7

// ----------------------------------------
// Enable control fields
// ----------------------------------------
`define EC_RX_DONE_IRQ_EN 7
`define EC_TX_DONE_IRQ_EN 6
`define EC_BUF_EMPTY_IRQ_EN 5
`define EC_RECEIVER_EN 4
`define EC_TRANSMITTER_EN 3
`define EC_CHAR_SIZE_MSB 2
`define EC_RX_NINTH_BIT 1
`define EC_TX_NINTH_BIT 0

// ----------------------------------------
// Frame format fields
// ----------------------------------------
`define FF_OP_MODE_HI 7
`define FF_OP_MODE_LO 6
`define FF_PARITY_HI 5
`define FF_PARITY_LO 4
`define FF_STOP_BITS 3
`define FF_SIZE1_ORDER 2
`define FF_SIZE0_PHASE 1
`define FF_POLARITY 0

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define RST_ENABLE_CONTROL 8'h00
`define RST_FRAME_FORMAT 8'h06
`define RST_BAUD_LOW 8'h00
`define RST_BAUD_HIGH 4'h0
`define BAUD_WIDTH 12

`endif

// File: design/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_RESERVED = 2'h2,
    MODE_MASTER_SPI = 2'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    PARITY_OFF = 2'h0,
    PARITY_RESERVED = 2'h1,
    PARITY_EVEN = 2'h2,
    PARITY_ODD = 2'h3
  } parity_t;

endpackage
`default_nettype wire

// File: tb/serial_far_model.sv
`default_nettype none
module serial_far_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic transmitter_on,
  input wire logic baud_tick,
  input wire logic tx_load,
  output logic tx_shift_empty,
  output logic tx_buf_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic buf_full_reg;
  logic [2:0] bits_left_reg;

  // ----------------------------------------
  // Transmit engine, one bit per baud tick
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      buf_full_reg <= 1'h0;
      bits_left_reg <= 3'h0;
    end
    else if (transmitter_on && buf_full_reg && bits_left_reg == 3'h0)
    begin
      buf_full_reg <= tx_load;
      bits_left_reg <= 3'h7;
    end
    else
    begin
      if (tx_load)
        buf_full_reg <= 1'h1;
      if (baud_tick && bits_left_reg != 3'h0)
        bits_left_reg <= bits_left_reg - 3'h1;
    end
  assign tx_shift_empty = (bits_left_reg == 3'h0);
  assign tx_buf_empty = !buf_full_reg;
endmodule
`default_nettype wire

// File: tb/serial_port_props.sv
`default_nettype none
module serial_port_props
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic global_irq_en,
  input wire logic rx_done_flag,
  input wire logic tx_done_flag,
  input wire logic buf_empty_flag,
  input wire logic tx_shift_empty,
  input wire logic tx_buf_empty,
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic buf_empty_irq,
  input wire logic receiver_on,
  input wire logic rx_flush,
  input wire logic rx_err_flags_valid,
  input wire logic transmitter_on,
  input wire logic [1:0] op_mode,
  input wire logic parity_en,
  input wire logic two_stop_bits,
  input wire logic tx_ninth_bit,
  input wire logic lsb_first,
  input wire logic sample_on_rising,
  input wire logic change_on_rising,
  input wire logic [11:0] baud_divisor,
  input wire logic baud_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rx_irq_gate: assert property (rx_done_irq |-> $past(global_irq_en && rx_done_flag))
    else $error("rx done irq without flag and global enable");
  a_tx_irq_gate: assert property (tx_done_irq |-> $past(global_irq_en && tx_done_flag))
    else $error("tx done irq without flag and global enable");
  a_empty_irq_gate: assert property (buf_empty_irq |-> $past(global_irq_en && buf_empty_flag))
    else $error("buffer empty irq without flag and global enable");
  a_tx_drain_first: assert property ($fell(transmitter_on) |-> $past(tx_shift_empty && tx_buf_empty))
    else $error("transmitter released with data pending");
  a_flush_pulse: assert property (rx_flush |=> !rx_flush && !receiver_on)
    else $error("flush not a single pulse");
  a_err_flags_off: assert property ($fell(receiver_on) |-> rx_flush && !rx_err_flags_valid)
    else $error("receiver disabled without flush and flag invalidation");
  a_spi_reserved_bits: assert property (op_mode == MODE_MASTER_SPI |-> !parity_en && !two_stop_bits && !tx_ninth_bit)
    else $error("reserved field active in spi mode");
  a_order_spi_only: assert property (lsb_first |-> op_mode == MODE_MASTER_SPI)
    else $error("data order active outside spi mode");
  a_async_no_edges: assert property (op_mode == MODE_ASYNC |-> !sample_on_rising && !change_on_rising)
    else $error("clock edges selected in async mode");
  a_tick_single: assert property (baud_tick && baud_divisor != 12'h000 |=> !baud_tick)
    else $error("baud tick wider than one cycle");
  c_flush: cover property (rx_flush);
  c_drain: cover property ($fell(transmitter_on));
  c_spi: cover property (op_mode == MODE_MASTER_SPI);
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
`include "serial_port_defs.svh"
module tb
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_EC = {2'h0, `IDX_ENABLE_CONTROL, 2'h0};
  localparam logic [11:0] A_FF = {2'h0, `IDX_FRAME_FORMAT, 2'h0};
  localparam logic [11:0] A_BL = {2'h0, `IDX_BAUD_LOW, 2'h0};
  localparam logic [11:0] A_BH = {2'h0, `IDX_BAUD_HIGH, 2'h0};
  typedef struct packed {
    logic [7:0] ec; logic [7:0] ff; logic [1:0] mode; logic [3:0] bits;
    logic pe; logic po; logic s2; logic lsb; logic smp; logic chg; logic res; logic idle;
  } row_t;
  row_t rows [12] = '{
    '{8'h00, 8'h00, 2'h0, 4'h5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h00, 8'h02, 2'h0, 4'h6, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h00, 8'h04, 2'h0, 4'h7, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h00, 8'h26, 2'h0, 4'h8, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h04, 8'h36, 2'h0, 4'h9, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h04, 8'h08, 2'h0, 4'h8, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0},
    '{8'h00, 8'h16, 2'h0, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{8'h00, 8'h46, 2'h1, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0},
    '{8'h00, 8'h47, 2'h1, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1},
    '{8'h04, 8'hfe, 2'h3, 4'h8, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0},
    '{8'h00, 8'hc1, 2'h3, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1},
    '{8'h00, 8'hc3, 2'h3, 4'h8, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1}};
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic global_irq_en = 1'h0, rx_done_flag = 1'h0, tx_done_flag = 1'h0, buf_empty_flag = 1'h0;
  logic rx_ninth_bit = 1'h0, tx_load = 1'h0, rerr, pready, pslverr, tx_shift_empty, tx_buf_empty;
  logic rx_done_irq, tx_done_irq, buf_empty_irq, receiver_on, rx_flush, rx_err_flags_valid;
  logic transmitter_on, char_size_reserved, parity_en, parity_odd, two_stop_bits, lsb_first;
  logic sample_on_rising, change_on_rising, clk_idle_high, tx_ninth_bit, baud_tick;
  logic [1:0] op_mode;
  logic [3:0] data_bits;
  logic [11:0] baud_divisor;
  int n_mismatch = 0, checks_done = 0, n_flush = 0;
  time t0, t1;

  serial_port_ctrl serial_port_ctrl_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .global_irq_en, .rx_done_flag, .tx_done_flag, .buf_empty_flag, .rx_ninth_bit,
    .tx_shift_empty, .tx_buf_empty, .rx_done_irq, .tx_done_irq, .buf_empty_irq, .receiver_on, .rx_flush,
    .rx_err_flags_valid, .transmitter_on, .op_mode, .data_bits, .char_size_reserved, .parity_en, .parity_odd,
    .two_stop_bits, .lsb_first, .sample_on_rising, .change_on_rising, .clk_idle_high, .tx_ninth_bit,
    .baud_divisor, .baud_tick);
  serial_far_model serial_far_model_inst (.pclk, .presetn, .transmitter_on, .baud_tick, .tx_load,
    .tx_shift_empty, .tx_buf_empty);

  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) if (rx_flush === 1'h1) n_flush++;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'h1)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    while (pready !== 1'h1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(rdat === {24'h0, e} && rerr === 1'h0, "register read");
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    chk(data_bits === 4'h8 && transmitter_on === 1'h0, "reset outputs");
    rd(A_FF, 8'h06);
    rd(A_EC, 8'h00);
    rd(A_BL, 8'h00);
    apb(1'h0, 12'h318, 8'h00);
    chk(rerr === 1'h1 && rdat === 32'h0, "unmapped read");
    foreach (rows[i])
    begin
      row_t r;
      r = rows[i];
      apb(1'h1, A_EC, r.ec);
      apb(1'h1, A_FF, r.ff);
      settle();
      chk({op_mode, data_bits, char_size_reserved} === {r.mode, r.bits, r.res}, "size decode");
      chk({parity_en, parity_odd, two_stop_bits} === {r.pe, r.po, r.s2}, "parity decode");
      chk({lsb_first, clk_idle_high} === {r.lsb, r.idle}, "order decode");
      chk({sample_on_rising, change_on_rising} === {r.smp, r.chg}, "edge decode");
      rd(A_FF, rows[i].ff);
    end
    rx_ninth_bit <= 1'h1;
    apb(1'h1, A_FF, 8'h06);
    apb(1'h1, A_EC, 8'h05);
    settle();
    chk(tx_ninth_bit === 1'h1 && data_bits === 4'h9, "ninth transmit bit");
    rd(A_EC, 8'h07);
    apb(1'h1, A_EC, 8'he0);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      {buf_empty_flag, tx_done_flag, rx_done_flag, global_irq_en} <= i[3:0];
      settle();
      chk(rx_done_irq === (i[0] & i[1]) && tx_done_irq === (i[0] & i[2]) && buf_empty_irq === (i[0] & i[3]),
        "irq gating");
    end
    apb(1'h1, A_EC, 8'h00);
    settle();
    chk({rx_done_irq, tx_done_irq, buf_empty_irq} === 3'h0, "irq masked");
    apb(1'h1, A_EC, 8'h10);
    settle();
    chk(receiver_on === 1'h1 && rx_err_flags_valid === 1'h1, "receiver on");
    apb(1'h1, A_EC, 8'h00);
    settle();
    chk(receiver_on === 1'h0 && rx_err_flags_valid === 1'h0 && n_flush == 1, "receiver off");
    apb(1'h1, A_BH, 8'hff);
    apb(1'h1, A_BL, 8'h03);
    settle();
    chk(baud_divisor === 12'hf03, "divisor value");
    rd(A_BH, 8'h0f);
    apb(1'h1, A_BH, 8'h00);
    apb(1'h1, A_BL, 8'h03);
    t0 = 0;
    t1 = 0;
    repeat (30)
    begin
      @(posedge pclk);
      if (baud_tick === 1'h1 && t0 == 0)
        t0 = $time;
      else if (baud_tick === 1'h1 && t1 == 0)
        t1 = $time;
    end
    chk(t1 - t0 == 80, "tick period after reload");
    apb(1'h1, A_EC, 8'h08);
    settle();
    chk(transmitter_on === 1'h1, "transmitter on");
    @(posedge pclk);
    tx_load <= 1'h1;
    repeat (2) @(posedge pclk);
    tx_load <= 1'h0;
    apb(1'h1, A_EC, 8'h00);
    settle();
    chk(transmitter_on === 1'h1 && tx_buf_empty === 1'h0, "drain pending");
    for (int n = 0; n < 200 && !(tx_shift_empty && tx_buf_empty); n++) @(posedge pclk);
    settle();
    chk(transmitter_on === 1'h0, "transmitter released");
    apb(1'h1, A_FF, 8'h41);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    chk(data_bits === 4'h8 && op_mode === 2'h0 && clk_idle_high === 1'h0, "mid-run reset outputs");
    rd(A_FF, 8'h06);
    rd(A_BL, 8'h00);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule

bind serial_port_ctrl serial_port_props serial_port_props_inst (.pclk, .presetn, .global_irq_en, .rx_done_flag,
  .tx_done_flag, .buf_empty_flag, .tx_shift_empty, .tx_buf_empty, .rx_done_irq, .tx_done_irq, .buf_empty_irq,
  .receiver_on, .rx_flush, .rx_err_flags_valid, .transmitter_on, .op_mode, .parity_en, .two_stop_bits,
  .tx_ninth_bit, .lsb_first, .sample_on_rising, .change_on_rising, .baud_divisor, .baud_tick);
`default_nettype wire
